//--- tuid_pkg.sv
/*
 * Package of the translation unit identification block: register offsets,
 * implementation constants, field positions, carrier structs and types.
 * Assumes one clock domain and a byte-addressed Avalon-MM register port.
 */
package tuid_pkg;

    // byte offsets, one aligned word each
    localparam logic [7:0] TUID_OFF_BANK_COUNTS  = 8'h00;
    localparam logic [7:0] TUID_OFF_FEATURES     = 8'h04;
    localparam logic [7:0] TUID_OFF_RESERVED_A   = 8'h08;
    localparam logic [7:0] TUID_OFF_IMPL_DEF_4   = 8'h0C;
    localparam logic [7:0] TUID_OFF_IMPL_DEF_5   = 8'h10;
    localparam logic [7:0] TUID_OFF_RESERVED_B   = 8'h14;
    localparam logic [7:0] TUID_OFF_VERSION      = 8'h18;
    localparam logic [7:0] TUID_OFF_AUX_CONFIG   = 8'h20;
    localparam logic [7:0] TUID_OFF_AUX_NS_ALIAS = 8'h24;
    localparam logic [7:0] TUID_OFF_SEC_CONTROL  = 8'h28;

    // implementation constants
    localparam logic [7:0]  TUID_TOTAL_BANKS     = 8'h10;
    localparam logic [7:0]  TUID_S2_ONLY_BANKS   = 8'h04;
    localparam logic        TUID_HAS_STAGE1      = 1'b1;
    localparam logic [7:0]  TUID_STAGE1_BANKS    = TUID_TOTAL_BANKS - TUID_S2_ONLY_BANKS;
    localparam logic        TUID_TWO_SEC_STATES  = 1'b1;
    localparam logic        TUID_ACCESS_NEVER    = 1'b1;
    localparam logic        TUID_COMP_INDEX      = 1'b1;
    localparam logic        TUID_HIER_ATTR       = 1'b1;
    localparam logic        TUID_HOST_EXT        = 1'b1;
    localparam logic        TUID_EXT_MATCH       = 1'b1;
    localparam logic [10:0] TUID_EXT_MATCH_COUNT = 11'h100;
    localparam logic [10:0] TUID_LEGACY_GROUPS   = 11'h080;
    localparam logic        TUID_WIDE_VMID       = 1'b1;
    localparam logic        TUID_GRANULE_64K     = 1'b1;
    localparam logic        TUID_GRANULE_16K     = 1'b0;
    localparam logic        TUID_GRANULE_4K      = 1'b1;
    localparam logic [3:0]  TUID_UPSTREAM_CODE   = 4'h5;
    localparam logic [3:0]  TUID_OUTPUT_CODE     = 4'h4;
    localparam logic [3:0]  TUID_INTERM_CODE     = 4'h4;
    // arbitrary values, no meaning beyond this block
    localparam logic [31:0] TUID_IMPL_DEF_4_VAL  = 32'h0000_0000;
    localparam logic [31:0] TUID_IMPL_DEF_5_VAL  = 32'h0000_0000;
    localparam logic [3:0]  TUID_VER_MAJOR       = 4'h1;
    localparam logic [3:0]  TUID_VER_MINOR       = 4'h0;

    // field positions
    localparam int TUID_POS_S2_COUNT    = 16;
    localparam int TUID_POS_ACCESS_NEV  = 30;
    localparam int TUID_POS_COMP_INDEX  = 29;
    localparam int TUID_POS_HIER_ATTR   = 28;
    localparam int TUID_POS_HOST_EXT    = 27;
    localparam int TUID_POS_EXT_COUNT   = 16;
    localparam int TUID_POS_WIDE_VMID   = 15;
    localparam int TUID_POS_G64K        = 14;
    localparam int TUID_POS_G16K        = 13;
    localparam int TUID_POS_G4K         = 12;
    localparam int TUID_POS_UPSTREAM    = 8;
    localparam int TUID_POS_OUTPUT      = 4;
    localparam int TUID_POS_CB_OVERRIDE = 0;
    localparam int TUID_POS_COMP_OFF    = 8;
    localparam int TUID_POS_NS_EXT      = 16;

    // reset values
    localparam logic [31:0] TUID_AUX_RESET    = 32'h0000_0000;
    localparam logic [7:0]  TUID_CB_OVR_RESET = TUID_TOTAL_BANKS;
    localparam logic        TUID_COMP_OFF_RST = 1'b0;
    localparam logic [10:0] TUID_NS_EXT_RESET = TUID_EXT_MATCH_COUNT;

    // privilege config encodings
    localparam logic [1:0] TUID_PRIV_DEFAULT = 2'h0;
    localparam logic [1:0] TUID_PRIV_NEVER   = 2'h1;
    localparam logic [1:0] TUID_PRIV_UNPRIV  = 2'h2;
    localparam logic [1:0] TUID_PRIV_PRIV    = 2'h3;

    typedef enum logic [1:0] {
        TUID_BANK_TWO_LEVEL,
        TUID_BANK_BYPASS,
        TUID_BANK_HYPERVISOR,
        TUID_BANK_MONITOR
    } tuid_bank_kind_type;

    typedef enum logic [3:0] {
        TUID_SEL_BANK_COUNTS, TUID_SEL_FEATURES, TUID_SEL_RESERVED, TUID_SEL_IMPL4,
        TUID_SEL_IMPL5, TUID_SEL_VERSION, TUID_SEL_AUX, TUID_SEL_AUX_ALIAS,
        TUID_SEL_SEC_CTRL, TUID_SEL_NONE
    } tuid_sel_type;

    typedef struct packed {
        logic        read;
        logic        write;
        logic        secure;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } tuid_avs_req_type;

    typedef struct packed {
        logic               valid;
        logic [1:0]         privilege_config;
        tuid_bank_kind_type kind;
        logic               txn_privileged;
        logic               region_unpriv;
    } tuid_priv_req_type;

    typedef struct packed {
        logic valid;
        logic privileged;
        logic perm_fault;
    } tuid_priv_ans_type;

endpackage : tuid_pkg

//--- tuid_regs.sv
/*
 * Identification register bank of the address translation unit, with the
 * banked auxiliary configuration register, a secure-only control word and
 * the privilege-config resolver for incoming transactions.
 * Assumes an Avalon-MM master on mclk with a secure sideband bit, and a
 * transaction source on the same clock.
 */
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
//Contract
// - bank count field reports all implemented context banks, 0 to 128, stage-2-only included
// - stage 1 capable banks equal total banks minus stage-2-only banks
// - non-secure read of total bank count returns the secure-set override value
// - feature bit 30 flags access-never support; bit 31 reads zero
// - access-never on two-level bank makes all privileged, faulting unprivileged-reachable regions
// - bypass context treats access-never encoding like privileged encoding
// - hypervisor and monitor banks treat access-never encoding like privileged encoding
// - bit 29 flags compressed indexing; non-secure reads zero when secure disable set
// - bit 28 flags hierarchical attribute disable support, 64-bit tables only
// - bit 27 flags host-extension translation context support
// - bits 26:16 give implemented group count secure, usable group count non-secure
// - extended group count includes 128 legacy groups; zero without extended matching
// - bit 15 reads 1 for 16-bit machine identifiers, 0 for 8-bit only
// - bits 14, 13, 12 flag 64KB, 16KB and 4KB granule support
// - bits 11:8 encode upstream bus width, codes 0 to 5 and 15
// - bits 7:4 encode maximum output address width, codes 0 to 5
// - bits 3:0 encode maximum intermediate address width, codes 0 to 5
// - third and sixth id registers reserved; fourth and fifth implementation defined
// - version register holds major in bits 7:4, minor in bits 3:0
// - auxiliary register is 32-bit read-write, banked per security state, with secure alias
// - bits 23:16 of bank count register report stage-2-only bank count
module tuid_regs (
    input  wire logic                        mclk,            // 125 MHz clock
    input  wire logic                        rst_n,           // synchronous reset
    input  wire tuid_pkg::tuid_avs_req_type  avs_req,         // avalon request group
    output logic     [31:0]                  avs_readdata,    // registered read data
    output logic                             avs_waitrequest, // stall until answer ready
    input  wire tuid_pkg::tuid_priv_req_type priv_req,        // transaction to resolve
    output tuid_pkg::tuid_priv_ans_type      priv_ans         // registered resolution
);
    import tuid_pkg::*;

    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [31:0]       aux_s;
        logic [31:0]       aux_ns;
        logic [7:0]        cb_override;
        logic              comp_off;
        logic [10:0]       ns_ext_count;
        tuid_priv_ans_type pans;
    } tuid_state_type;

    tuid_state_type s_q;
    tuid_state_type s_d;

    // one decode shared by read and write paths
    function automatic tuid_sel_type decode(input logic [7:0] addr);
        case (addr)
            TUID_OFF_BANK_COUNTS:  decode = TUID_SEL_BANK_COUNTS;
            TUID_OFF_FEATURES:     decode = TUID_SEL_FEATURES;
            TUID_OFF_RESERVED_A:   decode = TUID_SEL_RESERVED;
            TUID_OFF_IMPL_DEF_4:   decode = TUID_SEL_IMPL4;
            TUID_OFF_IMPL_DEF_5:   decode = TUID_SEL_IMPL5;
            TUID_OFF_RESERVED_B:   decode = TUID_SEL_RESERVED;
            TUID_OFF_VERSION:      decode = TUID_SEL_VERSION;
            TUID_OFF_AUX_CONFIG:   decode = TUID_SEL_AUX;
            TUID_OFF_AUX_NS_ALIAS: decode = TUID_SEL_AUX_ALIAS;
            TUID_OFF_SEC_CONTROL:  decode = TUID_SEL_SEC_CTRL;
            default:               decode = TUID_SEL_NONE;
        endcase
    endfunction : decode

    // byte-lane merge for writable words
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // feature word; secure view differs from non-secure view
    function automatic logic [31:0] features(input logic sec, input logic comp_off_v,
                                             input logic [10:0] ns_ext);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[TUID_POS_ACCESS_NEV] = TUID_ACCESS_NEVER;
        w[TUID_POS_COMP_INDEX] = TUID_COMP_INDEX & (sec | ~comp_off_v);
        w[TUID_POS_HIER_ATTR]  = TUID_HIER_ATTR;
        w[TUID_POS_HOST_EXT]   = TUID_HOST_EXT;
        if (TUID_EXT_MATCH) begin
            w[TUID_POS_EXT_COUNT +: 11] = sec ? TUID_EXT_MATCH_COUNT : ns_ext;
        end
        w[TUID_POS_WIDE_VMID]     = TUID_WIDE_VMID;
        w[TUID_POS_G64K]          = TUID_GRANULE_64K;
        w[TUID_POS_G16K]          = TUID_GRANULE_16K;
        w[TUID_POS_G4K]           = TUID_GRANULE_4K;
        w[TUID_POS_UPSTREAM +: 4] = TUID_UPSTREAM_CODE;
        w[TUID_POS_OUTPUT +: 4]   = TUID_OUTPUT_CODE;
        w[3:0]                    = TUID_INTERM_CODE;
        features = w;
    endfunction : features

    tuid_sel_type sel;
    logic         nonsec_view;
    logic         take_read;
    logic         take_write;
    logic [31:0]  rd_value;
    logic [31:0]  sec_ctrl_word;

    assign sel         = decode(avs_req.address);
    assign nonsec_view = TUID_TWO_SEC_STATES & ~avs_req.secure;
    // read data is loaded on the first edge, the answer shows one cycle later
    assign take_read   = avs_req.read & ~s_q.ack;
    // writes commit only at the edge where waitrequest is sampled low
    assign take_write  = avs_req.write & s_q.ack;

    assign sec_ctrl_word = {5'h00, s_q.ns_ext_count, 7'h00, s_q.comp_off, s_q.cb_override};

    // handshake: one wait cycle for every access, mapped or not
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s_q.ack;
    assign avs_readdata    = s_q.rdata;
    assign priv_ans        = s_q.pans;

    // read multiplexer
    always_comb begin
        rd_value = 32'h0000_0000;
        case (sel)
            TUID_SEL_BANK_COUNTS: begin
                rd_value[TUID_POS_S2_COUNT +: 8] = TUID_S2_ONLY_BANKS;
                rd_value[7:0] = nonsec_view ? s_q.cb_override : TUID_TOTAL_BANKS;
            end
            TUID_SEL_FEATURES: begin
                rd_value = features(~nonsec_view, s_q.comp_off, s_q.ns_ext_count);
            end
            TUID_SEL_RESERVED: begin
                rd_value = 32'h0000_0000;
            end
            TUID_SEL_IMPL4: begin
                rd_value = TUID_IMPL_DEF_4_VAL;
            end
            TUID_SEL_IMPL5: begin
                rd_value = TUID_IMPL_DEF_5_VAL;
            end
            TUID_SEL_VERSION: begin
                rd_value = {24'h00_0000, TUID_VER_MAJOR, TUID_VER_MINOR};
            end
            TUID_SEL_AUX: begin
                rd_value = nonsec_view ? s_q.aux_ns : s_q.aux_s;
            end
            TUID_SEL_AUX_ALIAS: begin
                rd_value = nonsec_view ? 32'h0000_0000 : s_q.aux_ns;
            end
            TUID_SEL_SEC_CTRL: begin
                rd_value = nonsec_view ? 32'h0000_0000 : sec_ctrl_word;
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // next-state logic: bus answer, writable words, privilege resolver
    always_comb begin
        s_d     = s_q;
        s_d.ack = (avs_req.read | avs_req.write) & ~s_q.ack;
        if (take_read) begin
            s_d.rdata = rd_value;
        end
        // id words have no write path at all
        if (take_write) begin
            case (sel)
                TUID_SEL_AUX: begin
                    if (nonsec_view) begin
                        s_d.aux_ns = merge(s_q.aux_ns, avs_req.writedata, avs_req.byteenable);
                    end else begin
                        s_d.aux_s = merge(s_q.aux_s, avs_req.writedata, avs_req.byteenable);
                    end
                end
                TUID_SEL_AUX_ALIAS: begin
                    if (!nonsec_view) begin
                        s_d.aux_ns = merge(s_q.aux_ns, avs_req.writedata, avs_req.byteenable);
                    end
                end
                TUID_SEL_SEC_CTRL: begin
                    // non-secure software may not steer its own view
                    if (!nonsec_view) begin
                        if (avs_req.byteenable[0]) begin
                            s_d.cb_override = avs_req.writedata[TUID_POS_CB_OVERRIDE +: 8];
                        end
                        if (avs_req.byteenable[1]) begin
                            s_d.comp_off = avs_req.writedata[TUID_POS_COMP_OFF];
                        end
                        if (avs_req.byteenable[2]) begin
                            s_d.ns_ext_count[7:0] = avs_req.writedata[TUID_POS_NS_EXT +: 8];
                        end
                        if (avs_req.byteenable[3]) begin
                            s_d.ns_ext_count[10:8] = avs_req.writedata[TUID_POS_NS_EXT + 8 +: 3];
                        end
                    end
                end
                default: begin
                    s_d.ack = 1'b0;
                end
            endcase
        end
        // privilege resolution, registered one cycle after the request
        s_d.pans.valid      = priv_req.valid;
        s_d.pans.privileged = priv_req.txn_privileged;
        s_d.pans.perm_fault = 1'b0;
        if (priv_req.valid) begin
            case (priv_req.privilege_config)
                TUID_PRIV_UNPRIV: begin
                    s_d.pans.privileged = 1'b0;
                end
                TUID_PRIV_PRIV: begin
                    s_d.pans.privileged = 1'b1;
                end
                TUID_PRIV_NEVER: begin
                    // without support the encoding is reserved; pass the request through
                    if (TUID_ACCESS_NEVER) begin
                        s_d.pans.privileged = 1'b1;
                        s_d.pans.perm_fault = (priv_req.kind == TUID_BANK_TWO_LEVEL)
                                              & priv_req.region_unpriv;
                    end
                end
                default: begin
                    s_d.pans.privileged = priv_req.txn_privileged;
                end
            endcase
            // these banks have no notion of unprivileged access
            if (priv_req.kind == TUID_BANK_HYPERVISOR || priv_req.kind == TUID_BANK_MONITOR) begin
                s_d.pans.perm_fault = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q.ack          <= 1'b0;
            s_q.rdata        <= 32'h0000_0000;
            s_q.aux_s        <= TUID_AUX_RESET;
            s_q.aux_ns       <= TUID_AUX_RESET;
            s_q.cb_override  <= TUID_CB_OVR_RESET;
            s_q.comp_off     <= TUID_COMP_OFF_RST;
            s_q.ns_ext_count <= TUID_NS_EXT_RESET;
            s_q.pans         <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // bus handshake answers within two cycles
    a_wait_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(avs_req.read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered on the second cycle");

    a_total_banks: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_BANK_COUNTS && !nonsec_view)
        |=> avs_readdata[7:0] == TUID_TOTAL_BANKS && avs_readdata[7:0] <= 8'h80)
        else $error("secure bank count wrong");

    a_stage1_split: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_BANK_COUNTS && !nonsec_view && TUID_HAS_STAGE1)
        |=> (avs_readdata[7:0] - avs_readdata[23:16]) == TUID_STAGE1_BANKS
            && avs_readdata[23:16] == TUID_S2_ONLY_BANKS && avs_readdata[31:24] == 8'h00)
        else $error("stage split of banks wrong");

    a_ns_override: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_BANK_COUNTS && nonsec_view)
        |=> avs_readdata[7:0] == $past(s_q.cb_override))
        else $error("non-secure bank count not the override");

    a_comp_hidden: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_FEATURES && nonsec_view && s_q.comp_off)
        |=> !avs_readdata[TUID_POS_COMP_INDEX] && !avs_readdata[31])
        else $error("compressed index visible to non-secure");

    a_ext_count: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_FEATURES)
        |=> avs_readdata[26:16] == ($past(nonsec_view) ? $past(s_q.ns_ext_count)
                                                       : TUID_EXT_MATCH_COUNT)
            && (!$past(!nonsec_view) || avs_readdata[26:16] >= TUID_LEGACY_GROUPS))
        else $error("extended group count wrong");

    a_feature_codes: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_FEATURES)
        |=> avs_readdata[15:0] == {TUID_WIDE_VMID, TUID_GRANULE_64K, TUID_GRANULE_16K,
                                   TUID_GRANULE_4K, TUID_UPSTREAM_CODE, TUID_OUTPUT_CODE,
                                   TUID_INTERM_CODE})
        else $error("feature size codes wrong");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && (sel == TUID_SEL_RESERVED || sel == TUID_SEL_NONE))
        |=> avs_readdata == 32'h0000_0000)
        else $error("reserved word not zero");

    a_version_word: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_read && sel == TUID_SEL_VERSION) |=> avs_readdata[31:8] == 24'h00_0000
            && avs_readdata[7:4] == TUID_VER_MAJOR && avs_readdata[3:0] == TUID_VER_MINOR)
        else $error("version word wrong");

    a_aux_alias: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_write && sel == TUID_SEL_AUX_ALIAS && !nonsec_view && avs_req.byteenable == 4'hF)
        |=> s_q.aux_ns == $past(avs_req.writedata) && $stable(s_q.aux_s))
        else $error("secure alias did not reach non-secure copy");

    a_never_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (priv_req.valid && priv_req.privilege_config == TUID_PRIV_NEVER
         && priv_req.kind == TUID_BANK_TWO_LEVEL && TUID_ACCESS_NEVER)
        |=> priv_ans.valid && priv_ans.privileged && priv_ans.perm_fault == $past(priv_req.region_unpriv))
        else $error("access-never resolution wrong");

    a_never_as_priv: assert property (@(posedge mclk) disable iff (!rst_n)
        (priv_req.valid && priv_req.privilege_config == TUID_PRIV_NEVER
         && priv_req.kind != TUID_BANK_TWO_LEVEL && TUID_ACCESS_NEVER)
        |=> priv_ans.privileged && !priv_ans.perm_fault)
        else $error("access-never not treated as privileged");

    // writes share the single wait cycle of reads
    a_write_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(avs_req.write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("write not answered on the second cycle");

    a_id_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_write && (sel == TUID_SEL_BANK_COUNTS || sel == TUID_SEL_FEATURES || sel == TUID_SEL_VERSION))
        |=> $stable(s_q.aux_s) && $stable(s_q.aux_ns) && $stable(s_q.cb_override) && $stable(s_q.comp_off))
        else $error("write to id word changed state");

    a_ns_ctrl_locked: assert property (@(posedge mclk) disable iff (!rst_n)
        (take_write && sel == TUID_SEL_SEC_CTRL && nonsec_view)
        |=> $stable(s_q.cb_override) && $stable(s_q.comp_off) && $stable(s_q.ns_ext_count))
        else $error("non-secure write reached secure control");

    a_hyp_no_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (priv_req.valid && (priv_req.kind == TUID_BANK_HYPERVISOR || priv_req.kind == TUID_BANK_MONITOR))
        |=> priv_ans.valid && !priv_ans.perm_fault)
        else $error("hypervisor or monitor bank faulted");

endmodule : tuid_regs

//--- tuid_regs_tb.sv
/*
 * Self-checking bench of the identification register bank: bus reads and
 * writes over Avalon-MM, security banking, and the privilege resolver.
 * Assumes the design package is compiled first and one 125 MHz clock.
 */
module tuid_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tuid_pkg::*;

    logic              mclk;
    logic              rst_n;
    tuid_avs_req_type  avs_req;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    tuid_priv_req_type priv_req;
    tuid_priv_ans_type priv_ans;
    int                num_errors;
    int                checked;
    logic              pv;
    logic              pf;

    // expected id words, built from the implementation constants
    localparam logic [31:0] BANK = {8'h00, TUID_S2_ONLY_BANKS, 8'h00, TUID_TOTAL_BANKS};
    localparam logic [31:0] FEAT = {1'b0, TUID_ACCESS_NEVER, TUID_COMP_INDEX, TUID_HIER_ATTR,
        TUID_HOST_EXT, TUID_EXT_MATCH_COUNT, TUID_WIDE_VMID, TUID_GRANULE_64K, TUID_GRANULE_16K,
        TUID_GRANULE_4K, TUID_UPSTREAM_CODE, TUID_OUTPUT_CODE, TUID_INTERM_CODE};

    tuid_regs tuid_regs_i (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .avs_req         (avs_req),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .priv_req        (priv_req),
        .priv_ans        (priv_ans)
    );

    // free-running clock, 8 ns period
    always #4 mclk = ~mclk;

    task automatic end_of_test;
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one bus transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic sec, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_req <= '{read: !wr, write: wr, secure: sec, address: a, writedata: d, byteenable: 4'hF};
        // read at the edge, before the design's registers move: same view as the slave
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
    endtask : bus

    task automatic rd(input logic sec, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, sec, a, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic wr(input logic sec, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, sec, a, d, q);
    endtask : wr

    // watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #40000;
        num_errors++;
        end_of_test();
    end

    initial begin
        mclk       = 1'b0;
        rst_n      = 1'b0;
        avs_req    = '0;
        priv_req   = '0;
        num_errors = 0;
        checked    = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd(1'b1, TUID_OFF_AUX_CONFIG, TUID_AUX_RESET);
        rd(1'b1, TUID_OFF_BANK_COUNTS, BANK);
        rd(1'b1, TUID_OFF_FEATURES, FEAT);
        wr(1'b1, TUID_OFF_FEATURES, 32'hFFFF_FFFF);
        wr(1'b1, TUID_OFF_BANK_COUNTS, 32'h0000_0000);
        rd(1'b0, TUID_OFF_FEATURES, FEAT);
        rd(1'b0, TUID_OFF_BANK_COUNTS, BANK);
        rd(1'b1, TUID_OFF_RESERVED_A, 32'h0);
        rd(1'b1, TUID_OFF_IMPL_DEF_4, TUID_IMPL_DEF_4_VAL);
        rd(1'b1, TUID_OFF_IMPL_DEF_5, TUID_IMPL_DEF_5_VAL);
        rd(1'b1, TUID_OFF_RESERVED_B, 32'h0);
        rd(1'b1, TUID_OFF_VERSION, {24'h0, TUID_VER_MAJOR, TUID_VER_MINOR});
        rd(1'b1, 8'h40, 32'h0);
        // secure control: override 5, compressed index off, 128 groups
        wr(1'b1, TUID_OFF_SEC_CONTROL, 32'h0080_0105);
        wr(1'b0, TUID_OFF_SEC_CONTROL, 32'h0000_0000);
        rd(1'b0, TUID_OFF_BANK_COUNTS, {BANK[31:8], 8'h05});
        rd(1'b0, TUID_OFF_FEATURES, {FEAT[31:30], 1'b0, FEAT[28:27], 11'h080, FEAT[15:0]});
        rd(1'b1, TUID_OFF_FEATURES, FEAT);
        rd(1'b0, TUID_OFF_SEC_CONTROL, 32'h0);
        // banked aux words and the secure alias of the non-secure copy
        wr(1'b1, TUID_OFF_AUX_CONFIG, 32'hA5A5_0001);
        wr(1'b0, TUID_OFF_AUX_CONFIG, 32'h5A5A_0002);
        rd(1'b1, TUID_OFF_AUX_CONFIG, 32'hA5A5_0001);
        rd(1'b1, TUID_OFF_AUX_NS_ALIAS, 32'h5A5A_0002);
        wr(1'b1, TUID_OFF_AUX_NS_ALIAS, 32'h0123_4567);
        wr(1'b0, TUID_OFF_AUX_NS_ALIAS, 32'hFFFF_FFFF);
        rd(1'b0, TUID_OFF_AUX_CONFIG, 32'h0123_4567);
        rd(1'b0, TUID_OFF_AUX_NS_ALIAS, 32'h0);
        // every config and bank kind, each with two of the four privilege/region mixes
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk);
            priv_req <= tuid_priv_req_type'({1'b1, i[1:0], i[3:2], i[4], i[0] ^ i[4]});
            pv = (i[1:0] == 2'h0) ? i[4] : (i[1:0] != 2'h2);
            pf = (i[1:0] == 2'h1) && (i[3:2] == 2'h0) && (i[0] ^ i[4]);
            @(posedge mclk);
            #1;
            chk({29'h0, priv_ans}, {29'h0, 1'b1, pv, pf});
        end
        priv_req.valid <= 1'b0;
        end_of_test();
    end
endmodule : tuid_regs_tb
